// [verilog/fcs_flash_command_sequencer.sv]
// Flash command sequencer: AHB-Lite slave for the flash window and two
// control registers, plus the command-sequence state machine.
// Assumes one AHB master, an array that reads combinationally while
// fa_rd_en is high, and one-cycle fa_done (with fa_fail) per operation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Security enable is read/write bit 0
// - Cold reset alone sets security enable to 1
// - Read mode after reset and normal completion
// - Command enters auto mode; identification read stays
// - No array reads served while busy
// - Hardware reset aborts; reads resume after 2 ms
// - Wrong address or data aborts to read
// - Read and read/reset commands cancel sequences; during page data entry a read/reset code is taken as data
// - Ready flag 0 while running, 1 after
// - Commands ignored while busy; only reset stops
// - Abnormal end locks busy until hardware reset
// - Page program stays inside one page
// - Programming only clears bits to zero
// - Protected blocks are never programmed
// - Chip erase skips protected blocks
// - Chip erase is six cycles, then starts
// - Command data bytes follow fixed codes
// - Ready flag is status register bit 0
module fcs_flash_command_sequencer
  import fcs_pkg::*;
#(
  parameter int unsigned RECOV_CYCLES = RECOV_CYCLES_DEF
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic      [1:0]            hresp,
  output logic      [31:0]           hrdata,
  input  wire logic                  warm_reset,
  input  wire logic [NUM_BLOCKS-1:0] blk_protect,
  output logic      [FLASH_AW-1:0]   fa_addr,
  output logic                       fa_rd_en,
  input  wire logic [31:0]           fa_rdata,
  output logic                       fa_prog_en,
  output logic      [31:0]           fa_wdata,
  output logic                       fa_erase_en,
  output logic      [NUM_BLOCKS-1:0] fa_erase_mask,
  input  wire logic                  fa_done,
  input  wire logic                  fa_fail,
  output logic                       ready_busy_flag,
  output logic                       security_enable,
  output logic                       security_active
);

  localparam int PROT_EXT_W = 1 << BLK_IDX_W;

  fcs_state_t                state_reg;
  fcs_state_t                state_next;
  logic [PAGE_IDX_W-1:0]     pcnt_reg;
  logic [PAGE_IDX_W-1:0]     pcnt_next;
  logic [PAGE_NUM_W-1:0]     base_reg;
  logic [PAGE_NUM_W-1:0]     base_next;
  logic                      buf_we;
  logic [31:0]               buf_rdata;
  logic                      sec_reg;
  logic [RECOV_W-1:0]        recov_reg;
  logic                      dp_wr_reg;
  logic [DP_AW-1:0]          dp_addr_reg;
  logic [2:0]                dp_size_reg;
  logic                      rd_wait_reg;
  logic [31:0]               hrdata_reg;
  logic [FLASH_AW-1:0]       fa_addr_reg;
  logic [31:0]               fa_wdata_reg;
  logic                      fa_prog_reg;
  logic                      fa_erase_reg;
  logic [NUM_BLOCKS-1:0]     erase_mask_reg;

  // Address-phase decode
  wire                       ap_take    = hsel & htrans[1] & hready;
  wire                       ap_flash   = ~haddr[ADDR_REGION_BIT];
  wire [7:0]                 ap_off     = haddr[7:0];

  // Data-phase decode; writes always finish in a single data cycle
  wire                       dp_flash   = ~dp_addr_reg[ADDR_REGION_BIT];
  wire [7:0]                 dp_off     = dp_addr_reg[7:0];
  wire                       sec_wr     = dp_wr_reg & ~dp_flash & (dp_off == REG_SEC_OFF);
  wire                       cmd_fire   = dp_wr_reg & dp_flash & (dp_size_reg == HSIZE_WORD);
  wire [7:0]                 cmd_byte   = hwdata[7:0];
  wire                       at_lo      = dp_addr_reg[15:8] == CMD_ADDR_LO;
  wire                       at_hi      = dp_addr_reg[15:8] == CMD_ADDR_HI;
  wire                       is_u1      = cmd_byte == CMD_UNLOCK1;
  wire                       is_u2      = cmd_byte == CMD_UNLOCK2;
  wire                       is_f0      = cmd_byte == CMD_READ_RESET;

  // Mode decode from the state register
  wire                       prog_busy  = (state_reg == ST_PROG_RD) | (state_reg == ST_PROG_LD)
                                        | (state_reg == ST_PROG_WAIT);
  wire                       auto_busy  = prog_busy | (state_reg == ST_ERASE_WAIT);
  wire                       locked     = state_reg == ST_LOCK;
  wire                       in_ident   = state_reg == ST_IDENT;
  wire                       rd_ok      = ~auto_busy & ~locked & ~in_ident & (recov_reg == '0);
  wire                       sec_on     = sec_reg & (&blk_protect);

  // Page and block arithmetic
  wire [PAGE_IDX_W-1:0]      dp_widx    = dp_addr_reg[PAGE_LSB-1:2];
  wire [PAGE_NUM_W-1:0]      dp_page    = dp_addr_reg[FLASH_AW-1:PAGE_LSB];
  wire [FLASH_AW-1:0]        page_addr  = {base_reg, {PAGE_LSB{1'b0}}};
  wire [BLK_IDX_W-1:0]       blk_idx    = page_addr[BLK_LSB +: BLK_IDX_W];
  wire [PROT_EXT_W-1:0]      prot_ext   = {{(PROT_EXT_W - NUM_BLOCKS){1'b1}}, blk_protect};
  wire                       page_prot  = prot_ext[blk_idx];
  wire                       next_word  = (dp_page == base_reg) && (dp_widx == pcnt_reg);
  wire                       last_word  = pcnt_reg == PAGE_IDX_W'(PAGE_WORDS - 1);

  // Register read mux; unmapped offsets read as zero
  wire [31:0]                sec_view   = {31'h0000_0000, sec_reg};
  wire [31:0]                fcs_view   = {10'h000, blk_protect, 15'h0000, ready_busy_flag};
  wire [31:0]                reg_rdata  = (ap_off == REG_SEC_OFF) ? sec_view :
                                          (ap_off == REG_FCS_OFF) ? fcs_view : 32'h0000_0000;

  // Sequencer next state: command decode and the program/erase engine
  always_comb begin
    state_next = state_reg;
    pcnt_next  = pcnt_reg;
    base_next  = base_reg;
    buf_we     = 1'b0;
    case (state_reg)
      ST_READ: begin
        if (cmd_fire && !sec_on && at_lo && is_u1) begin
          state_next = ST_C1;
        end
      end
      ST_C1: begin
        if (cmd_fire) begin
          state_next = (at_hi && is_u2) ? ST_C2 : ST_READ;
        end
      end
      ST_C2: begin
        if (cmd_fire) begin
          if (at_lo && cmd_byte == CMD_PROGRAM) begin
            state_next = ST_PA;
          end else if (at_lo && cmd_byte == CMD_ERASE_SETUP) begin
            state_next = ST_E3;
          end else if (at_lo && cmd_byte == CMD_IDENT) begin
            state_next = ST_IDENT;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_PA: begin
        // First data word must sit at the start of a page
        if (cmd_fire) begin
          if (dp_widx == '0) begin
            base_next  = dp_page;
            buf_we     = 1'b1;
            pcnt_next  = PAGE_IDX_W'(1);
            state_next = ST_PD;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_PD: begin
        // Data words here may equal any code, so no software reset
        if (cmd_fire) begin
          if (next_word) begin
            buf_we = 1'b1;
            if (last_word) begin
              pcnt_next  = '0;
              state_next = page_prot ? ST_READ : ST_PROG_RD;
            end else begin
              pcnt_next = pcnt_reg + PAGE_IDX_W'(1);
            end
          end else begin
            // A cut page must not leave a stale word index for the next one
            pcnt_next  = '0;
            state_next = ST_READ;
          end
        end
      end
      ST_E3: begin
        if (cmd_fire) begin
          state_next = (at_lo && is_u1) ? ST_E4 : ST_READ;
        end
      end
      ST_E4: begin
        if (cmd_fire) begin
          state_next = (at_hi && is_u2) ? ST_E5 : ST_READ;
        end
      end
      ST_E5: begin
        if (cmd_fire) begin
          if (at_lo && cmd_byte == CMD_CHIP_ERASE) begin
            state_next = (&blk_protect) ? ST_READ : ST_ERASE_WAIT;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_IDENT: begin
        // Stays until a read/reset code at any address or a first unlock write at the command address arrives
        if (cmd_fire) begin
          if (is_f0) begin
            state_next = ST_READ;
          end else if (at_lo && is_u1) begin
            state_next = ST_C1;
          end
        end
      end
      ST_PROG_RD: begin
        state_next = ST_PROG_LD;
      end
      ST_PROG_LD: begin
        state_next = ST_PROG_WAIT;
      end
      ST_PROG_WAIT: begin
        // New stores are not looked at while the engine runs
        if (fa_done) begin
          if (fa_fail) begin
            state_next = ST_LOCK;
          end else if (last_word) begin
            pcnt_next  = '0;
            state_next = ST_READ;
          end else begin
            pcnt_next  = pcnt_reg + PAGE_IDX_W'(1);
            state_next = ST_PROG_RD;
          end
        end
      end
      ST_ERASE_WAIT: begin
        if (fa_done) begin
          state_next = fa_fail ? ST_LOCK : ST_READ;
        end
      end
      ST_LOCK: begin
        state_next = ST_LOCK;
      end
      default: begin
        state_next = ST_READ;
      end
    endcase
    // Warm reset abandons whatever was running
    if (warm_reset) begin
      state_next = ST_READ;
      pcnt_next  = '0;
    end
  end

  // Sequencer registers; cold reset lands in read mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_READ;
      pcnt_reg  <= '0;
      base_reg  <= '0;
    end else begin
      state_reg <= state_next;
      pcnt_reg  <= pcnt_next;
      base_reg  <= base_next;
    end
  end

  // Security bit survives warm reset; only cold reset sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_reg <= SEC_RESET;
    end else if (sec_wr) begin
      sec_reg <= hwdata[SEC_BIT_POS];
    end
  end

  // Recovery wait after a warm reset that cut an operation short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recov_reg <= '0;
    end else if (warm_reset && (auto_busy || locked)) begin
      recov_reg <= RECOV_W'(RECOV_CYCLES);
    end else if (recov_reg != '0) begin
      recov_reg <= recov_reg - RECOV_W'(1);
    end
  end

  // Bus data-phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= '0;
      dp_size_reg <= '0;
    end else if (hready) begin
      dp_wr_reg   <= ap_take & hwrite;
      dp_addr_reg <= haddr[DP_AW-1:0];
      dp_size_reg <= hsize;
    end
  end

  // Read data: registers and refused reads answer at once, array adds one wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_reg <= 1'b0;
      hrdata_reg  <= '0;
    end else if (rd_wait_reg) begin
      rd_wait_reg <= 1'b0;
      hrdata_reg  <= fa_rdata;
    end else if (ap_take && !hwrite) begin
      rd_wait_reg <= ap_flash & rd_ok;
      if (!ap_flash) begin
        hrdata_reg <= reg_rdata;
      end else if (in_ident) begin
        hrdata_reg <= IDENT_CODE;
      end else begin
        hrdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Array address: bus reads in read mode, page words while programming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fa_addr_reg <= '0;
    end else if (ap_take && !hwrite && ap_flash && rd_ok) begin
      fa_addr_reg <= haddr[FLASH_AW-1:0];
    end else if (state_reg == ST_PROG_RD) begin
      fa_addr_reg <= {base_reg, pcnt_reg, 2'b00};
    end
  end

  // Program and erase strobes, one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fa_wdata_reg   <= '1;
      fa_prog_reg    <= 1'b0;
      fa_erase_reg   <= 1'b0;
      erase_mask_reg <= '0;
    end else begin
      fa_prog_reg  <= (state_reg == ST_PROG_LD) & ~warm_reset;
      fa_erase_reg <= (state_next == ST_ERASE_WAIT) & (state_reg != ST_ERASE_WAIT);
      if (state_reg == ST_PROG_LD) begin
        // Merge with old contents so no cell is asked to go 0 to 1
        fa_wdata_reg <= buf_rdata & fa_rdata;
      end
      if (state_reg == ST_E5) begin
        erase_mask_reg <= ~blk_protect;
      end
    end
  end

  fcs_page_buffer u_page_buffer (
    .hclk    (hclk),
    .wr_en   (buf_we),
    .wr_idx  (pcnt_reg),
    .wr_data (hwdata),
    .rd_idx  (pcnt_reg),
    .rd_data (buf_rdata)
  );

  // Bus answers: always OKAY, wait state only for array reads
  assign hreadyout       = ~rd_wait_reg;
  assign hresp           = HRESP_OKAY;
  assign hrdata          = hrdata_reg;

  // Array side
  assign fa_addr         = fa_addr_reg;
  assign fa_rd_en        = rd_wait_reg | (state_reg == ST_PROG_LD);
  assign fa_prog_en      = fa_prog_reg;
  assign fa_wdata        = fa_wdata_reg;
  assign fa_erase_en     = fa_erase_reg;
  assign fa_erase_mask   = erase_mask_reg;

  // Status; ready drops the cycle after the last command word
  assign ready_busy_flag = ~(auto_busy | locked);
  assign security_enable = sec_reg;
  assign security_active = sec_on;

endmodule

`default_nettype wire

// [verilog/fcs_pkg.sv]
// Shared constants and the state type of the flash command sequencer.
// Assumes a 10 MHz bus clock and a word-wide flash array behind the block.
package fcs_pkg;

  // Clock rate and hardware-reset recovery time before reads resume
  localparam int          CLK_MHZ          = 10;
  localparam int          RECOV_TIME_MS    = 2;
  localparam int          RECOV_CYCLES_DEF = RECOV_TIME_MS * 1000 * CLK_MHZ;
  localparam int          RECOV_W          = 16;

  // Address map: bit 20 splits the flash window from the register window
  localparam int          ADDR_REGION_BIT  = 20;
  localparam int          DP_AW            = ADDR_REGION_BIT + 1;
  localparam int          FLASH_AW         = 17;
  localparam logic [7:0]  REG_SEC_OFF      = 8'h10;
  localparam logic [7:0]  REG_FCS_OFF      = 8'h14;

  // Register fields and reset values
  localparam int          SEC_BIT_POS      = 0;
  localparam int          RDY_BIT_POS      = 0;
  localparam int          PROT_LSB         = 16;
  localparam logic        SEC_RESET        = 1'b1;

  // Flash geometry: pages of words, blocks selected by upper address bits
  localparam int          NUM_BLOCKS       = 6;
  localparam int          BLK_IDX_W        = 3;
  localparam int          BLK_LSB          = 14;
  localparam int          PAGE_WORDS       = 16;
  localparam int          PAGE_IDX_W       = 4;
  localparam int          PAGE_LSB         = PAGE_IDX_W + 2;
  localparam int          PAGE_NUM_W       = FLASH_AW - PAGE_LSB;

  // Command address high bytes and data low bytes
  localparam logic [7:0]  CMD_ADDR_LO      = 8'h54;
  localparam logic [7:0]  CMD_ADDR_HI      = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK1      = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2      = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM      = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
  localparam logic [7:0]  CMD_READ_RESET   = 8'hf0;
  localparam logic [7:0]  CMD_IDENT        = 8'h90;

  // AHB encodings used by the slave
  localparam logic [2:0]  HSIZE_WORD       = 3'b010;
  localparam logic [1:0]  HRESP_OKAY       = 2'b00;

  // Identification word returned in identification read mode (arbitrary value)
  localparam logic [31:0] IDENT_CODE       = 32'h0000_5a01;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_READ       = 4'b0000,
    ST_C1         = 4'b0001,
    ST_C2         = 4'b0010,
    ST_PA         = 4'b0011,
    ST_PD         = 4'b0100,
    ST_E3         = 4'b0101,
    ST_E4         = 4'b0110,
    ST_E5         = 4'b0111,
    ST_IDENT      = 4'b1000,
    ST_PROG_RD    = 4'b1001,
    ST_PROG_LD    = 4'b1010,
    ST_PROG_WAIT  = 4'b1011,
    ST_ERASE_WAIT = 4'b1100,
    ST_LOCK       = 4'b1101
  } fcs_state_t;

endpackage

// [verilog/fcs_page_buffer.sv]
// One page of program words, filled by the command sequence and
// drained word by word while the page program runs.
// Assumes write and read never need the same entry in one cycle.
`timescale 1ns/1ps
`default_nettype none

module fcs_page_buffer
  import fcs_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  wr_en,
  input  wire logic [PAGE_IDX_W-1:0] wr_idx,
  input  wire logic [31:0]           wr_data,
  input  wire logic [PAGE_IDX_W-1:0] rd_idx,
  output logic      [31:0]           rd_data
);

  logic [31:0] mem [PAGE_WORDS];

  // Storage needs no reset: a page is always filled before it is used
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Read is combinational so the engine can merge in the same cycle
  assign rd_data = mem[rd_idx];

endmodule

`default_nettype wire

// [dv/fcs_props.sv]
// Port-level checker for the flash command sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fcs_props
  import fcs_pkg::*;
#(
  parameter int unsigned RECOV_CYCLES = 20000
) (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic [31:0]           hrdata,
  input wire logic                  warm_reset,
  input wire logic [NUM_BLOCKS-1:0] blk_protect,
  input wire logic [FLASH_AW-1:0]   fa_addr,
  input wire logic                  fa_prog_en,
  input wire logic                  fa_erase_en,
  input wire logic [NUM_BLOCKS-1:0] fa_erase_mask,
  input wire logic                  fa_done,
  input wire logic                  fa_fail,
  input wire logic                  ready_busy_flag,
  input wire logic                  security_enable,
  input wire logic                  security_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Busy whenever the erase strobe is high
  property p_erase_busy;
    fa_erase_en |-> !ready_busy_flag;
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase while ready");
  // Busy only falls when an operation really starts
  property p_start;
    $fell(ready_busy_flag) |-> fa_erase_en or ##2 fa_prog_en;
  endproperty
  a_start: assert property (p_start) else $error("busy without operation");
  // Ready returns only after a good finish or a warm reset
  property p_done;
    $rose(ready_busy_flag) |-> $past(warm_reset) || ($past(fa_done) && !$past(fa_fail));
  endproperty
  a_done: assert property (p_done) else $error("ready without good finish");
  // A failed operation keeps ready low for the next four cycles
  property p_lock;
    fa_done && fa_fail && !warm_reset |=> !ready_busy_flag [*4];
  endproperty
  a_lock: assert property (p_lock) else $error("lock released early");
  property p_warm;
    warm_reset |=> ready_busy_flag;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset left busy");
  // Array reads while busy answer zero with no wait
  property p_busy_read;
    !ready_busy_flag && hsel && htrans[1] && !hwrite && !haddr[ADDR_REGION_BIT] && hready
      |=> hreadyout && hrdata == 32'h0;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("array read while busy");
  property p_prot;
    fa_prog_en |-> fa_addr[BLK_LSB+:BLK_IDX_W] < 3'd6 && !blk_protect[fa_addr[BLK_LSB+:BLK_IDX_W]];
  endproperty
  a_prot: assert property (p_prot) else $error("protected block programmed");
  property p_mask;
    fa_erase_en |-> fa_erase_mask == ~blk_protect && fa_erase_mask != '0;
  endproperty
  a_mask: assert property (p_mask) else $error("erase mask wrong");
  property p_secact;
    security_active == (security_enable && &blk_protect);
  endproperty
  a_secact: assert property (p_secact) else $error("security state wrong");
endmodule
bind fcs_flash_command_sequencer fcs_props #(.RECOV_CYCLES(RECOV_CYCLES)) i_fcs_props (.*);
`default_nettype wire

// [dv/fcs_flash_model.sv]
// Behavioural flash array on the far side of the sequencer.
// Assumes one operation at a time; lat and fail_next are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model
  import fcs_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic [FLASH_AW-1:0]   fa_addr,
  input  wire logic                  fa_rd_en,
  output logic      [31:0]           fa_rdata,
  input  wire logic                  fa_prog_en,
  input  wire logic [31:0]           fa_wdata,
  input  wire logic                  fa_erase_en,
  input  wire logic [NUM_BLOCKS-1:0] fa_erase_mask,
  output logic                       fa_done = 1'b0,
  output logic                       fa_fail = 1'b0
);
  localparam int W = 2 ** (FLASH_AW - 2);
  logic [31:0] mem [0:W-1];
  logic [31:0] last = 32'h0;
  int          lat = 3;
  logic        fail_next = 1'b0;
  int          cnt = 0;
  initial
    for (int i = 0; i < W; i++)
      mem[i] = 32'hffffffff;
  // Idle bus shows the inverse of the last word, not a stale copy
  assign fa_rdata = fa_rd_en ? mem[fa_addr[FLASH_AW-1:2]] : ~last;
  // Program, erase, then a done pulse after lat cycles
  always @(posedge hclk) begin
    fa_done <= 1'b0;
    fa_fail <= 1'b0;
    if (fa_rd_en)
      last <= fa_rdata;
    if (fa_prog_en) begin
      mem[fa_addr[FLASH_AW-1:2]] <= mem[fa_addr[FLASH_AW-1:2]] & fa_wdata;
      cnt <= lat;
    end else if (fa_erase_en) begin
      for (int i = 0; i < NUM_BLOCKS * 4096; i++)
        if (fa_erase_mask[i / 4096])
          mem[i] <= 32'hffffffff;
      cnt <= lat;
    end else if (cnt == 1) begin
      fa_done <= 1'b1;
      fa_fail <= fail_next;
      cnt <= 0;
    end else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// [dv/fcs_flash_command_sequencer_bench.sv]
// Self-checking bench: AHB-Lite master tasks, sequencer and array model.
// Assumes the recovery count is shortened to RC cycles.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_command_sequencer_bench;
  import fcs_pkg::*;
  localparam int          RC = 20;
  localparam logic [31:0] RB = 32'h0010_0000;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, warm_reset = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, fa_wdata, fa_rdata;
  logic [1:0]  htrans = 0, hresp;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [5:0]  blk_protect = 0, fa_erase_mask;
  logic [16:0] fa_addr;
  logic hreadyout, fa_rd_en, fa_prog_en, fa_erase_en, fa_done, fa_fail;
  logic ready_busy_flag, security_enable, security_active;
  int   err_total = 0;
  int   n_tests = 0;
  fcs_flash_command_sequencer #(.RECOV_CYCLES(RC)) i_fcs_flash_command_sequencer (
    .hready(hreadyout), .*);
  fcs_flash_model i_fcs_flash_model (.*);
  always #50 hclk = ~hclk;

  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic hw();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic xf(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hw();
    htrans <= 2'b00;
    hwdata <= d;
    hw();
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xf(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    xf(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  function automatic logic [31:0] st(input logic b);
    return {10'h0, blk_protect, 15'h0, b};
  endfunction
  function automatic logic [31:0] pd(input int b, i);
    return 32'h5a5a_0000 + b * 16 + i;
  endfunction
  task automatic cmd(input logic [7:0] hi, d);
    wr({16'h0, hi, 8'h00}, {24'h0, d});
  endtask
  task automatic unl();
    cmd(CMD_ADDR_LO, CMD_UNLOCK1);
    cmd(CMD_ADDR_HI, CMD_UNLOCK2);
  endtask
  task automatic prog(input int b);
    unl();
    cmd(CMD_ADDR_LO, CMD_PROGRAM);
    for (int i = 0; i < PAGE_WORDS; i++)
      wr(b + 4 * i, pd(b, i));
  endtask
  task automatic erase();
    unl();
    cmd(CMD_ADDR_LO, CMD_ERASE_SETUP);
    unl();
    cmd(CMD_ADDR_LO, CMD_CHIP_ERASE);
  endtask
  // Poll the status register until ready, bounded
  task automatic wrdy();
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      xf(1'b0, RB | REG_FCS_OFF, 32'h0, r);
      n++;
    end while (r[0] !== 1'b1 && n < 500);
    chk(r[0], 1'b1);
  endtask

  task automatic s_regs();
    rd(RB | REG_SEC_OFF, 32'h1);
    rd(RB | REG_FCS_OFF, st(1'b1));
    rd(RB | 8'h18, 32'h0);
    wr(RB | REG_FCS_OFF, 32'h0);
    rd(RB | REG_FCS_OFF, st(1'b1));
    wr(RB | REG_SEC_OFF, 32'hffff_fffe);
    rd(RB | REG_SEC_OFF, 32'h0);
    chk({hresp, security_enable}, {HRESP_OKAY, 1'b0});
    warm_reset <= 1'b1;
    @(posedge hclk);
    warm_reset <= 1'b0;
    rd(RB | REG_SEC_OFF, 32'h0);
  endtask
  task automatic s_prog();
    blk_protect <= 6'b000010;
    i_fcs_flash_model.mem[19] = 32'h0f0f_0f0f;
    i_fcs_flash_model.lat = 20;
    prog(32'h40);
    rd(RB | REG_FCS_OFF, st(1'b0));
    rd(32'h40, 32'h0);
    erase(); // ignored while busy
    wrdy();
    for (int i = 0; i < PAGE_WORDS; i++)
      rd(32'h40 + 4 * i, pd(32'h40, i) & (i == 3 ? 32'h0f0f_0f0f : 32'hffffffff));
    rd(32'h80, 32'hffffffff);
    prog(32'h4000);
    rd(RB | REG_FCS_OFF, st(1'b1));
    rd(32'h4000, 32'hffffffff);
  endtask
  task automatic s_cmds();
    for (int k = 0; k < 2; k++) begin
      unl();
      cmd(CMD_ADDR_LO, CMD_IDENT);
      rd(32'h0, IDENT_CODE);
      if (k == 0)
        wr(32'h0, {24'h0, CMD_READ_RESET});
      else begin
        unl();
        cmd(CMD_ADDR_LO, CMD_READ_RESET);
      end
      rd(32'h44, pd(32'h40, 1));
      unl();
      if (k == 0)
        cmd(CMD_ADDR_HI, CMD_PROGRAM);
      else begin
        wr(32'h0, {24'h0, CMD_READ_RESET});
        cmd(CMD_ADDR_LO, CMD_PROGRAM);
      end
      for (int i = 0; i < PAGE_WORDS; i++)
        wr(32'h100 + 4 * i, pd(32'h100, i));
      rd(RB | REG_FCS_OFF, st(1'b1));
      rd(32'h100, 32'hffffffff);
    end
  endtask
  task automatic s_erase();
    blk_protect <= 6'b000001;
    i_fcs_flash_model.mem[4096] = 32'h0;
    erase();
    rd(RB | REG_FCS_OFF, st(1'b0));
    wrdy();
    rd(32'h40, pd(32'h40, 0));
    rd(32'h4000, 32'hffffffff);
    blk_protect <= 6'h3f;
    i_fcs_flash_model.mem[4096] = 32'h0;
    erase();
    rd(RB | REG_FCS_OFF, st(1'b1));
    rd(32'h4000, 32'h0);
  endtask
  task automatic s_fail();
    blk_protect <= 6'h0;
    i_fcs_flash_model.lat = 3;
    i_fcs_flash_model.fail_next = 1'b1;
    erase();
    repeat (12) @(posedge hclk);
    rd(RB | REG_FCS_OFF, st(1'b0));
    rd(32'h0, 32'h0);
    i_fcs_flash_model.fail_next = 1'b0;
    warm_reset <= 1'b1;
    @(posedge hclk);
    warm_reset <= 1'b0;
    rd(RB | REG_FCS_OFF, st(1'b1));
    rd(32'h40, 32'h0);
    repeat (RC) @(posedge hclk);
    rd(32'h40, 32'hffffffff);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(RB | REG_SEC_OFF, 32'h1);
    blk_protect <= 6'h3f;
    @(posedge hclk);
    chk(security_active, 1'b1);
    wr(RB | REG_SEC_OFF, 32'h0);
    @(posedge hclk);
    chk(security_active, 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs();
    s_prog();
    s_cmds();
    s_erase();
    s_fail();
    end_sim();
  end
endmodule
`default_nettype wire
